/* File: design/epi_top.sv */
// pin interrupt detection for the dedicated request pin and ports a, b, d
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module epi_top #(
    parameter int W = 8                       // pins per port
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          irq_pin,       // dedicated request pin
    input  wire logic [3*W-1:0] port_pins,    // ports a, b, d packed low to high
    output logic               irq_pull_en,   // internal pull on dedicated pin
    output logic               irq_pull_up,   // 1 pull-up, 0 pull-down
    output logic [3*W-1:0]     port_pull_up,  // per pin pull-up on
    output logic [3*W-1:0]     port_pull_dn,  // per pin pull-down on
    output logic [3*W-1:0]     pin_high_drive,// per pin high drive strength
    output logic               cpu_irq_req,   // request toward the cpu
    output logic               wake_req       // wake from stop or wait
);
    // register storage
    logic [6:0]     irq_ctl_r;                // mod, ie, pe, edg, pdd in their bits
    logic           irq_pin_flag_r;
    logic [2:0]     port_int_detect_mode_r;
    logic [2:0]     port_int_enable_r;
    logic [2:0]     port_int_flag_r;
    logic [3*W-1:0] port_int_pin_select_reg_r;
    logic [3*W-1:0] edge_sel_r;
    logic [3*W-1:0] drive_r;
    // synchronisers and previous samples
    logic           irq_s1_r, irq_s2_r, irq_prev_r;
    logic [3*W-1:0] p_s1_r, p_s2_r, p_prev_r;
    logic [31:0]    prdata_r;
    logic           cpu_irq_r, wake_r;
    logic           pu_r, pen_r;
    logic [3*W-1:0] ppu_r, ppd_r;

    // apb decode
    wire            acc       = psel && penable;
    wire            wr        = acc && pwrite;
    wire [31:0]     wd        = pwdata;
    wire            hit_irq   = paddr == epi_pkg::IRQ_SC_OFS;
    wire            hit_lvl   = paddr == epi_pkg::PIN_LVL_OFS;
    wire [2:0]      hit_sc    = {paddr == epi_pkg::PD_SC_OFS, paddr == epi_pkg::PB_SC_OFS,
                                 paddr == epi_pkg::PA_SC_OFS};
    wire [2:0]      hit_ps    = {paddr == epi_pkg::PD_PS_OFS, paddr == epi_pkg::PB_PS_OFS,
                                 paddr == epi_pkg::PA_PS_OFS};
    wire [2:0]      hit_es    = {paddr == epi_pkg::PD_ES_OFS, paddr == epi_pkg::PB_ES_OFS,
                                 paddr == epi_pkg::PA_ES_OFS};
    wire [2:0]      hit_ds    = {paddr == epi_pkg::DS_D_OFS, paddr == epi_pkg::DS_B_OFS,
                                 paddr == epi_pkg::DS_A_OFS};
    wire            mapped    = hit_irq || hit_lvl || (|hit_sc) || (|hit_ps) || (|hit_es)
                                || (|hit_ds);

    // dedicated pin control fields
    wire            irq_mode  = irq_ctl_r[epi_pkg::SC_MOD_BIT];
    wire            irq_ie    = irq_ctl_r[epi_pkg::SC_IE_BIT];
    wire            irq_en    = irq_ctl_r[epi_pkg::SC_PE_BIT];
    wire            irq_rise  = irq_ctl_r[epi_pkg::SC_EDG_BIT];
    wire            irq_pull_disable = irq_ctl_r[epi_pkg::SC_PDD_BIT];
    // asserted level of the dedicated pin after polarity
    wire            irq_act   = irq_s2_r ~^ irq_rise;
    wire            irq_actp  = irq_prev_r ~^ irq_rise;
    wire            irq_edge  = irq_en && irq_act && !irq_actp;
    wire            irq_hold  = irq_en && irq_mode && irq_act;
    wire            irq_ack   = wr && hit_irq && wd[epi_pkg::SC_ACK_BIT];
    wire            irq_flag_nxt = irq_edge || irq_hold ||
                                   (irq_pin_flag_r && !irq_ack);

    // port pin asserted levels: select 0 low active, 1 high active
    wire [3*W-1:0]  p_act     = ~(p_s2_r ^ edge_sel_r);
    wire [3*W-1:0]  p_actp    = ~(p_prev_r ^ edge_sel_r);
    // edge: previous sample deasserted, current asserted, pin selected
    wire [3*W-1:0]  p_edge    = port_int_pin_select_reg_r & p_act & ~p_actp;
    wire [3*W-1:0]  p_lvl     = port_int_pin_select_reg_r & p_act;
    logic [2:0]     port_set;
    logic [2:0]     port_ack;
    logic [2:0]     port_flag_nxt;

    // per-port set, acknowledge and next flag
    always_comb
    begin
        for (int k = 0; k < 3; k++)
        begin
            port_set[k] = (|p_edge[k*W +: W]) ||
                          (port_int_detect_mode_r[k] && (|p_lvl[k*W +: W]));
            port_ack[k] = wr && hit_sc[k] && wd[epi_pkg::SC_ACK_BIT];
            port_flag_nxt[k] = port_set[k] || (port_int_flag_r[k] && !port_ack[k]);
        end
    end

    // read data mux
    logic [31:0]    rd_nxt;
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        for (int k = 0; k < 3; k++)
        begin
            if (hit_sc[k])
            begin
                rd_nxt[epi_pkg::SC_MOD_BIT] = port_int_detect_mode_r[k];
                rd_nxt[epi_pkg::SC_IE_BIT]  = port_int_enable_r[k];
                rd_nxt[epi_pkg::SC_IF_BIT]  = port_int_flag_r[k];
            end
            else if (hit_ps[k])
                rd_nxt[W-1:0] = port_int_pin_select_reg_r[k*W +: W];
            else if (hit_es[k])
                rd_nxt[W-1:0] = edge_sel_r[k*W +: W];
            else if (hit_ds[k])
                rd_nxt[W-1:0] = drive_r[k*W +: W];
        end
        if (hit_irq)
        begin
            rd_nxt[6:0] = irq_ctl_r;
            rd_nxt[epi_pkg::SC_ACK_BIT] = 1'b0;
            rd_nxt[epi_pkg::SC_IF_BIT]  = irq_pin_flag_r;
        end
        else if (hit_lvl)
            rd_nxt[0] = irq_en ? irq_s2_r : 1'b0;
    end

    // two-stage synchronisers, then one extra sample for edge compare
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_s1_r   <= 1'b0;
            irq_s2_r   <= 1'b0;
            irq_prev_r <= 1'b0;
            p_s1_r     <= '0;
            p_s2_r     <= '0;
            p_prev_r   <= '0;
        end
        else
        begin
            irq_s1_r   <= irq_pin;
            irq_s2_r   <= irq_s1_r;
            irq_prev_r <= irq_s2_r;
            p_s1_r     <= port_pins;
            p_s2_r     <= p_s1_r;
            p_prev_r   <= p_s2_r;
        end
    end

    // register writes and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ctl_r                 <= '0;
            irq_pin_flag_r            <= 1'b0;
            port_int_detect_mode_r    <= '0;
            port_int_enable_r         <= '0;
            port_int_flag_r           <= '0;
            port_int_pin_select_reg_r <= '0;
            edge_sel_r                <= '0;
            drive_r                   <= '0;
        end
        else
        begin
            irq_pin_flag_r  <= irq_flag_nxt;
            port_int_flag_r <= port_flag_nxt;
            if (wr && hit_irq)
            begin
                irq_ctl_r <= wd[6:0];
                irq_ctl_r[epi_pkg::SC_ACK_BIT] <= 1'b0;
                irq_ctl_r[epi_pkg::SC_IF_BIT]  <= 1'b0;
            end
            for (int k = 0; k < 3; k++)
            begin
                if (wr && hit_sc[k])
                begin
                    port_int_detect_mode_r[k] <= wd[epi_pkg::SC_MOD_BIT];
                    port_int_enable_r[k]      <= wd[epi_pkg::SC_IE_BIT];
                end
                if (wr && hit_ps[k])
                    port_int_pin_select_reg_r[k*W +: W] <= wd[W-1:0];
                if (wr && hit_es[k])
                    edge_sel_r[k*W +: W] <= wd[W-1:0];
                if (wr && hit_ds[k])
                    drive_r[k*W +: W] <= wd[W-1:0];
            end
        end
    end

    // registered outputs: bus answer, pulls, request, wake
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h0000_0000;
            cpu_irq_r <= 1'b0;
            wake_r    <= 1'b0;
            pen_r     <= 1'b0;
            pu_r      <= 1'b0;
            ppu_r     <= '0;
            ppd_r     <= '0;
        end
        else
        begin
            prdata_r  <= (psel && !penable) ? rd_nxt : prdata_r;
            cpu_irq_r <= (irq_flag_nxt && irq_ie) ||
                         (|(port_flag_nxt & port_int_enable_r));
            wake_r    <= (irq_flag_nxt && irq_ie) ||
                         (|(port_flag_nxt & port_int_enable_r));
            pen_r     <= irq_en && !irq_pull_disable;
            pu_r      <= !irq_rise;
            ppu_r     <= port_int_pin_select_reg_r & ~edge_sel_r;
            ppd_r     <= port_int_pin_select_reg_r & edge_sel_r;
        end
    end

    assign prdata         = prdata_r;
    assign pready         = 1'b1;
    assign pslverr        = 1'b0;
    assign irq_pull_en    = pen_r;
    assign irq_pull_up    = pu_r;
    assign port_pull_up   = ppu_r;
    assign port_pull_dn   = ppd_r;
    assign pin_high_drive = drive_r;
    assign cpu_irq_req    = cpu_irq_r;
    assign wake_req       = wake_r;

    // dedicated pin seen deasserted then asserted, rising polarity, pin enabled
    sequence s_irq_rise;
        (irq_en && irq_rise && !irq_s2_r) ##1 (irq_en && irq_rise && irq_s2_r);
    endsequence
    // port a pin 0 selected for falling edges, seen high then low
    sequence s_pa0_fall;
        (port_int_pin_select_reg_r[0] && !edge_sel_r[0] && p_s2_r[0]) ##1
        (port_int_pin_select_reg_r[0] && !edge_sel_r[0] && !p_s2_r[0]);
    endsequence

    // flag keeps set while pin held asserted in edge-and-level mode
    chk_irq_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
        irq_hold |=> irq_pin_flag_r) else $error("pin flag not held");
    // acknowledge clears a port flag when no new event
    chk_port_ack_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (port_ack[0] && !port_set[0]) |=> !port_int_flag_r[0])
        else $error("port flag not cleared");
    // request is exactly an enabled flag, one cycle behind the enables
    chk_req_enable: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq_req == ((irq_pin_flag_r && $past(irq_ie)) ||
                        (|(port_int_flag_r & $past(port_int_enable_r)))))
        else $error("request does not follow flags");
    // a rising edge on the enabled dedicated pin sets its flag
    chk_irq_rise_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_irq_rise |=> irq_pin_flag_r) else $error("pin edge not flagged");
    // a falling edge on port a pin 0, when selected, sets the port a flag
    chk_port_edge_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_pa0_fall |=> port_int_flag_r[0]) else $error("port edge not flagged");
    // a port pin never gets pull-up and pull-down together
    chk_pull_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        (port_pull_up & port_pull_dn) == '0) else $error("both pulls on");
    // wake request tracks the cpu request
    chk_wake_match: assert property (@(posedge pclk) disable iff (!presetn)
        wake_req == cpu_irq_req) else $error("wake differs from request");
endmodule // epi_top

/* File: inc/epi_pkg.sv */
// package: register map, field positions, reset values for the pin interrupt block
package epi_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] IRQ_SC_OFS    = 8'h00; // dedicated pin control and status
    localparam logic [7:0] PA_SC_OFS     = 8'h04; // port a status and control
    localparam logic [7:0] PA_PS_OFS     = 8'h08; // port a pin select
    localparam logic [7:0] PA_ES_OFS     = 8'h0c; // port a edge select
    localparam logic [7:0] PB_SC_OFS     = 8'h10; // port b status and control
    localparam logic [7:0] PB_PS_OFS     = 8'h14; // port b pin select
    localparam logic [7:0] PB_ES_OFS     = 8'h18; // port b edge select
    localparam logic [7:0] PD_SC_OFS     = 8'h1c; // port d status and control
    localparam logic [7:0] PD_PS_OFS     = 8'h20; // port d pin select
    localparam logic [7:0] PD_ES_OFS     = 8'h24; // port d edge select
    localparam logic [7:0] DS_A_OFS      = 8'h28; // port a drive strength
    localparam logic [7:0] DS_B_OFS      = 8'h2c; // port b drive strength
    localparam logic [7:0] DS_D_OFS      = 8'h30; // port d drive strength
    localparam logic [7:0] PIN_LVL_OFS   = 8'h34; // dedicated pin level for level-test branches
    // status and control field positions (port and dedicated pin share layout)
    localparam int SC_MOD_BIT            = 0;     // detect mode: 1 edge and level
    localparam int SC_IE_BIT             = 1;     // local interrupt enable
    localparam int SC_ACK_BIT            = 2;     // write 1 clears flag, reads 0
    localparam int SC_IF_BIT             = 3;     // interrupt flag, read only
    localparam int SC_PE_BIT             = 4;     // dedicated pin enable
    localparam int SC_EDG_BIT            = 5;     // dedicated pin polarity: 1 rising/high
    localparam int SC_PDD_BIT            = 6;     // dedicated pin pull disable
    // reset values
    localparam logic [7:0] RST_BYTE      = 8'h00;
endpackage

/* File: dv/epi_pin_src.sv */
// model of the outside sources on the dedicated pin and the port pins
`timescale 1ns/1ps
module epi_pin_src #(
    parameter int N = 25              // pins modelled
) (
    input  wire logic         pclk,
    input  wire logic [N-1:0] oe,     // source drives the pin
    input  wire logic [N-1:0] dv,     // driven level
    input  wire logic [N-1:0] pu,     // pull-up on
    input  wire logic [N-1:0] pd,     // pull-down on
    output logic      [N-1:0] pins    // level seen at the pin
);
    logic [N-1:0] flt_r = '0;         // floating pattern
    // an undriven pin with no pull changes every cycle
    always_ff @(posedge pclk)
        flt_r <= ~flt_r;
    // driver first, then the pull device, else floating
    always_comb
        for (int i = 0; i < N; i++)
            pins[i] = oe[i] ? dv[i] : (pu[i] | ~pd[i] & flt_r[i]);
endmodule // epi_pin_src

/* File: dv/epi_top_tb.sv */
// self-checking bench for the pin interrupt detection block
`timescale 1ns/1ps
module epi_top_tb;
    // row: source, pin, polarity, mode, enable, expected request, flag after early ack
    typedef struct packed {
        logic [1:0] tgt;              // 0 dedicated pin, 1..3 ports a, b, d
        logic [2:0] bt;               // pin within the port
        logic       edg;              // 1 rising or high
        logic       md;               // 1 edge and level
        logic       ie;               // local enable
        logic       req;              // expected request
        logic       hold;             // flag kept by ack while asserted
    } epi_row_s;
    localparam epi_row_s ROWS [8] = '{
        '{2'd0, 3'd0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1},
        '{2'd0, 3'd0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
        '{2'd1, 3'd0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
        '{2'd1, 3'd7, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1},
        '{2'd2, 3'd3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
        '{2'd2, 3'd4, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
        '{2'd3, 3'd5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{2'd3, 3'd6, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}};
    logic        pclk = 1'b0, presetn = 1'b0;    // clock, reset active low
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;        // rd: last read word
    logic        pready, pslverr, irq_pull_en, irq_pull_up, cpu_irq_req, wake_req;
    logic [24:0] oe = '0, dv = '0, pins;         // bit 24 is the dedicated pin
    logic [24:0] pu_w, pd_w;                     // pull device per pin
    logic [23:0] port_pull_up, port_pull_dn, pin_high_drive;
    epi_row_s    r;                              // current row
    int          p;                              // pin index
    logic        irq;                            // row uses the dedicated pin
    logic [7:0]  sco, scv;                       // status offset and written value
    int          error_cnt = 0, n_checks = 0;

    assign pu_w = {irq_pull_en & irq_pull_up, port_pull_up};
    assign pd_w = {irq_pull_en & ~irq_pull_up, port_pull_dn};

    // free running bus clock
    always #50 pclk = ~pclk;

    epi_top #(.W(8)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_pin(pins[24]), .port_pins(pins[23:0]), .irq_pull_en(irq_pull_en),
        .irq_pull_up(irq_pull_up), .port_pull_up(port_pull_up), .port_pull_dn(port_pull_dn),
        .pin_high_drive(pin_high_drive), .cpu_irq_req(cpu_irq_req), .wake_req(wake_req)
    );
    epi_pin_src #(.N(25)) u_src (.pclk(pclk), .oe(oe), .dv(dv), .pu(pu_w), .pd(pd_w), .pins(pins));

    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    // apb transfer: setup on the next edge, access until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // read a register and compare
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(rd, e, "register read");
    endtask
    // wait whole cycles
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // counts, verdict, end of run
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // cuts a hang short; the tests need a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        report_and_stop;
    end

    // main sequence: reset, table rows, then hand-written cases
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk({cpu_irq_req, wake_req, irq_pull_en, irq_pull_up, pin_high_drive}, '0, "reset");
        for (int a = 0; a <= 'h34; a += 4)
            rdchk(8'(a), '0);
        foreach (ROWS[i])
        begin
            r = ROWS[i];
            irq = (r.tgt == 2'd0);
            p = irq ? 24 : (r.tgt - 1) * 8 + r.bt;
            sco = irq ? epi_pkg::IRQ_SC_OFS : epi_pkg::PA_SC_OFS + 8'(12 * (r.tgt - 1));
            scv = {2'b00, r.edg & irq, irq, 2'b00, r.ie, r.md};
            oe[p] <= 1'b1;
            dv[p] <= !r.edg;
            // port rows: select the pin and its polarity
            if (!irq)
            begin
                apb(1'b1, sco + 8'h04, 32'(1) << r.bt);
                apb(1'b1, sco + 8'h08, 32'(r.edg) << r.bt);
            end
            apb(1'b1, sco, 32'(scv));
            wt(6);
            chk(pu_w[p], !r.edg, "pull-up");
            chk(pd_w[p], r.edg, "pull-down");
            rdchk(sco, 32'(scv));
            dv[p] <= r.edg;
            wt(6);
            rdchk(sco, 32'(scv | 8'h08));
            chk(cpu_irq_req, r.req, "request");
            chk(wake_req, r.req, "wake");
            if (irq)
                rdchk(epi_pkg::PIN_LVL_OFS, 32'(r.edg));
            apb(1'b1, sco, 32'(scv | 8'h04));
            wt(2);
            rdchk(sco, 32'(scv | {r.hold, 3'b000}));
            dv[p] <= !r.edg;
            wt(6);
            apb(1'b1, sco, 32'(scv | 8'h04));
            wt(2);
            rdchk(sco, 32'(scv));
            chk(cpu_irq_req, 1'b0, "request off");
            apb(1'b1, irq ? sco : sco + 8'h04, '0);
        end
        // unselected pin ignored; pin already asserted at select gives no edge
        oe[16] <= 1'b1;
        dv[16] <= 1'b1;
        apb(1'b1, epi_pkg::PD_SC_OFS, 32'h2);
        dv[16] <= 1'b0;
        wt(6);
        rdchk(epi_pkg::PD_SC_OFS, 32'h2);
        apb(1'b1, epi_pkg::PD_PS_OFS, 32'h1);
        wt(6);
        rdchk(epi_pkg::PD_SC_OFS, 32'h2);
        dv[16] <= 1'b1;
        wt(6);
        dv[16] <= 1'b0;
        wt(6);
        rdchk(epi_pkg::PD_SC_OFS, 32'ha);
        apb(1'b1, epi_pkg::IRQ_SC_OFS, 32'h50);
        wt(2);
        chk(irq_pull_en, 1'b0, "pull disable");
        apb(1'b1, epi_pkg::DS_B_OFS, 32'ha5);
        wt(2);
        chk(pin_high_drive, 24'h00a500, "drive");
        rdchk(8'h3c, '0);
        chk(pslverr, 1'b0, "no error");
        presetn <= 1'b0;
        wt(2);
        chk(pin_high_drive, '0, "second reset");
        chk(cpu_irq_req, 1'b0, "request in reset");
        presetn <= 1'b1;
        wt(2);
        chk(irq_pull_up, 1'b1, "pull-up after reset");
        rdchk(epi_pkg::PD_SC_OFS, '0);
        chk(cpu_irq_req, 1'b0, "request after reset");
        report_and_stop;
    end
endmodule // epi_top_tb
